// ### rtl/sbie_consts.svh
`ifndef SBIE_CONSTS_SVH
`define SBIE_CONSTS_SVH

// Register bus
`define SBIE_ADDR_W          8
`define SBIE_DATA_W          8
`define SBIE_ADDR_STATUS     8'h00
`define SBIE_ADDR_ENABLE     8'h01
`define SBIE_ADDR_TX_LEVEL   8'h02
`define SBIE_ADDR_RX_LEVEL   8'h03

// Status and enable share one layout
`define SBIE_BIT_TX_OVERFLOW 7
`define SBIE_BIT_TX_UNDERFLOW 6
`define SBIE_BIT_TX_SLIP     5
`define SBIE_BIT_RX_OVERFLOW 2
`define SBIE_BIT_RX_UNDERFLOW 1
`define SBIE_BIT_RX_SLIP     0
`define SBIE_IMPL_MASK       8'hE7
`define SBIE_ENABLE_RESET    8'h00
`define SBIE_STATUS_RESET    8'h00

// Slip buffer geometry: two E1 frames of 32 timeslots
`define SBIE_PTR_W           6
`define SBIE_CNT_W           7
`define SBIE_FRAME_LEN       32
`define SBIE_DEPTH           64
`define SBIE_DIR_RX          0
`define SBIE_DIR_TX          1

`endif

// ### rtl/sbie_pkg.sv
`include "sbie_consts.svh"

package sbie_pkg;

    typedef struct packed {
        logic                      valid;
        logic [`SBIE_DATA_W-1:0]   data;
    } sbie_byte_type;

    typedef struct packed {
        logic [`SBIE_ADDR_W-1:0]   addr;
        logic [`SBIE_DATA_W-1:0]   wdata;
        logic                      wr;
        logic                      rd;
    } sbie_reg_req_type;

endpackage : sbie_pkg

// ### rtl/sbie_top.sv
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "sbie_consts.svh"

// How it works
// - Enable bit 7 gates the transmit overflow interrupt; read/write, resets to 0.
// - Enable bit 6 gates the transmit underflow interrupt; read/write, resets to 0.
// - Enable bit 5 gates the transmit slip interrupt, raised on overflow or underflow.
// - Write into full transmit buffer with no read in the same cycle drops a frame, sets overflow and slip status.
// - Read from empty transmit buffer replays a frame, sets underflow and slip status.
// - Enable bit 2 gates the receive overflow interrupt; read/write, resets to 0.
// - Enable bit 1 gates the receive underflow interrupt; read/write, resets to 0.
// - Enable bit 0 gates the receive slip interrupt, raised on overflow or underflow.
// - Write into full receive buffer with no read in the same cycle drops a frame, sets overflow and slip status.
// - Read from empty receive buffer replays a frame, sets underflow and slip status.
// - Status bits hold events until a status read, or a status write of 1 to the bit, and clear on either.
module sbie_top
    import sbie_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire sbie_reg_req_type        reg_req,
    output logic [`SBIE_DATA_W-1:0]      reg_rdata,
    input  wire sbie_byte_type           tx_wr,
    input  wire logic                    tx_rd_req,
    output sbie_byte_type                tx_rd_data,
    input  wire sbie_byte_type           rx_wr,
    input  wire logic                    rx_rd_req,
    output sbie_byte_type                rx_rd_data,
    output logic                         irq
);

    localparam logic [`SBIE_PTR_W-1:0] FRAME_PTR = `SBIE_PTR_W'(`SBIE_FRAME_LEN);
    localparam logic [`SBIE_CNT_W-1:0] FRAME_CNT = `SBIE_CNT_W'(`SBIE_FRAME_LEN);
    localparam logic [`SBIE_CNT_W-1:0] DEPTH_CNT = `SBIE_CNT_W'(`SBIE_DEPTH);

    function automatic logic [`SBIE_PTR_W-1:0] ptr_step(
        input logic [`SBIE_PTR_W-1:0] ptr,
        input logic                   inc
    );
        ptr_step = inc ? ptr + `SBIE_PTR_W'(1) : ptr;
    endfunction : ptr_step

    function automatic logic addr_hit(
        input logic [`SBIE_ADDR_W-1:0] addr,
        input logic [`SBIE_ADDR_W-1:0] target
    );
        addr_hit = (addr == target);
    endfunction : addr_hit

    sbie_byte_type               wr_in   [2];
    logic                        rd_in   [2];
    sbie_byte_type               rd_out_r[2];
    logic                        ovf     [2];
    logic                        unf     [2];
    logic [`SBIE_CNT_W-1:0]      cnt_r   [2];

    logic [`SBIE_DATA_W-1:0]     enable_r;
    logic [`SBIE_DATA_W-1:0]     status_r;
    logic [`SBIE_DATA_W-1:0]     status_nxt;
    logic [`SBIE_DATA_W-1:0]     status_set;
    logic [`SBIE_DATA_W-1:0]     status_clr;
    logic [`SBIE_DATA_W-1:0]     rdata_nxt;
    logic                        tx_overflow_irq_en;
    logic                        tx_underflow_irq_en;
    logic                        tx_slip_irq_en;
    logic                        rx_overflow_irq_en;
    logic                        rx_underflow_irq_en;
    logic                        rx_slip_irq_en;

    assign wr_in[`SBIE_DIR_RX] = rx_wr;
    assign wr_in[`SBIE_DIR_TX] = tx_wr;
    assign rd_in[`SBIE_DIR_RX] = rx_rd_req;
    assign rd_in[`SBIE_DIR_TX] = tx_rd_req;
    assign rx_rd_data          = rd_out_r[`SBIE_DIR_RX];
    assign tx_rd_data          = rd_out_r[`SBIE_DIR_TX];

    for (genvar g = 0; g < 2; g++) begin : g_buf
        logic [`SBIE_DATA_W-1:0] mem_r [`SBIE_DEPTH];
        logic [`SBIE_PTR_W-1:0]  wr_ptr_r;
        logic [`SBIE_PTR_W-1:0]  rd_ptr_r;
        logic [`SBIE_PTR_W-1:0]  rd_ptr_eff;
        logic [`SBIE_PTR_W-1:0]  rd_ptr_nxt;
        logic [`SBIE_CNT_W-1:0]  cnt_eff;
        logic [`SBIE_CNT_W-1:0]  cnt_nxt;
        logic                    full;
        logic                    empty;

        assign full  = (cnt_r[g] == DEPTH_CNT);
        assign empty = (cnt_r[g] == '0);
        // A read in the same cycle frees a slot, so no frame is lost then
        assign ovf[g] = wr_in[g].valid && full && !rd_in[g];
        assign unf[g] = rd_in[g] && empty;

        always_comb begin
            rd_ptr_eff = rd_ptr_r;
            cnt_eff    = cnt_r[g];
            if (unf[g]) begin
                // Step back over the last frame sent so it goes out again
                rd_ptr_eff = rd_ptr_r - FRAME_PTR;
                cnt_eff    = FRAME_CNT;
            end else if (ovf[g]) begin
                // Oldest frame is skipped to make room
                rd_ptr_eff = rd_ptr_r + FRAME_PTR;
                cnt_eff    = cnt_r[g] - FRAME_CNT;
            end
            rd_ptr_nxt = ptr_step(rd_ptr_eff, rd_in[g]);
            cnt_nxt    = cnt_eff;
            if (wr_in[g].valid && !rd_in[g]) begin
                cnt_nxt = cnt_eff + `SBIE_CNT_W'(1);
            end else if (!wr_in[g].valid && rd_in[g]) begin
                cnt_nxt = cnt_eff - `SBIE_CNT_W'(1);
            end
        end

        // Storage carries no reset; an underflow before a full frame is written replays bytes never written
        always_ff @(posedge sys_clk) begin
            if (wr_in[g].valid) begin
                mem_r[wr_ptr_r] <= wr_in[g].data;
            end
        end

        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                wr_ptr_r <= '0;
            end else begin
                wr_ptr_r <= ptr_step(wr_ptr_r, wr_in[g].valid);
            end
        end

        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                rd_ptr_r <= '0;
            end else begin
                rd_ptr_r <= rd_ptr_nxt;
            end
        end

        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                cnt_r[g] <= '0;
            end else begin
                cnt_r[g] <= cnt_nxt;
            end
        end

        always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                rd_out_r[g] <= '0;
            end else begin
                rd_out_r[g].valid <= rd_in[g];
                rd_out_r[g].data  <= rd_in[g] ? mem_r[rd_ptr_eff] : '0;
            end
        end
    end

    always_comb begin
        status_set = '0;
        status_set[`SBIE_BIT_TX_OVERFLOW]  = ovf[`SBIE_DIR_TX];
        status_set[`SBIE_BIT_TX_UNDERFLOW] = unf[`SBIE_DIR_TX];
        status_set[`SBIE_BIT_TX_SLIP]      = ovf[`SBIE_DIR_TX] | unf[`SBIE_DIR_TX];
        status_set[`SBIE_BIT_RX_OVERFLOW]  = ovf[`SBIE_DIR_RX];
        status_set[`SBIE_BIT_RX_UNDERFLOW] = unf[`SBIE_DIR_RX];
        status_set[`SBIE_BIT_RX_SLIP]      = ovf[`SBIE_DIR_RX] | unf[`SBIE_DIR_RX];
    end

    always_comb begin
        status_clr = '0;
        if (addr_hit(reg_req.addr, `SBIE_ADDR_STATUS)) begin
            if (reg_req.rd) begin
                status_clr = '1;
            end else if (reg_req.wr) begin
                status_clr = reg_req.wdata;
            end
        end
        // New events win over a clear in the same cycle
        status_nxt = ((status_r & ~status_clr) | status_set) & `SBIE_IMPL_MASK;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_r <= `SBIE_STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            enable_r <= `SBIE_ENABLE_RESET;
        end else if (reg_req.wr && addr_hit(reg_req.addr, `SBIE_ADDR_ENABLE)) begin
            enable_r <= reg_req.wdata & `SBIE_IMPL_MASK;
        end
    end

    always_comb begin
        rdata_nxt = '0;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `SBIE_ADDR_STATUS:   rdata_nxt = status_r;
                `SBIE_ADDR_ENABLE:   rdata_nxt = enable_r;
                `SBIE_ADDR_TX_LEVEL: rdata_nxt = {1'b0, cnt_r[`SBIE_DIR_TX]};
                `SBIE_ADDR_RX_LEVEL: rdata_nxt = {1'b0, cnt_r[`SBIE_DIR_RX]};
                default:             rdata_nxt = '0;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    assign tx_overflow_irq_en  = enable_r[`SBIE_BIT_TX_OVERFLOW];
    assign tx_underflow_irq_en = enable_r[`SBIE_BIT_TX_UNDERFLOW];
    assign tx_slip_irq_en      = enable_r[`SBIE_BIT_TX_SLIP];
    assign rx_overflow_irq_en  = enable_r[`SBIE_BIT_RX_OVERFLOW];
    assign rx_underflow_irq_en = enable_r[`SBIE_BIT_RX_UNDERFLOW];
    assign rx_slip_irq_en      = enable_r[`SBIE_BIT_RX_SLIP];

    // Level output: stays up until software clears or masks the cause
    // Next status is used so irq rises on the edge that sets the bit
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= (status_nxt[`SBIE_BIT_TX_OVERFLOW]  & tx_overflow_irq_en)
                 | (status_nxt[`SBIE_BIT_TX_UNDERFLOW] & tx_underflow_irq_en)
                 | (status_nxt[`SBIE_BIT_TX_SLIP]      & tx_slip_irq_en)
                 | (status_nxt[`SBIE_BIT_RX_OVERFLOW]  & rx_overflow_irq_en)
                 | (status_nxt[`SBIE_BIT_RX_UNDERFLOW] & rx_underflow_irq_en)
                 | (status_nxt[`SBIE_BIT_RX_SLIP]      & rx_slip_irq_en);
        end
    end

endmodule : sbie_top

// ### tb/sbie_top_props.sv
`timescale 1ns/1ps
`include "sbie_consts.svh"
module sbie_top_props
    import sbie_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             reset,
    input wire sbie_reg_req_type reg_req,
    input wire logic [7:0]       reg_rdata,
    input wire sbie_byte_type    tx_wr,
    input wire logic             tx_rd_req,
    input wire sbie_byte_type    tx_rd_data,
    input wire sbie_byte_type    rx_wr,
    input wire logic             rx_rd_req,
    input wire sbie_byte_type    rx_rd_data,
    input wire logic             irq
);
    logic [7:0] en_r;
    // Quiet buffers cannot raise a status event
    wire q = !(tx_wr.valid | tx_rd_req | rx_wr.valid | rx_rd_req);
    wire sr = reg_req.rd && reg_req.addr == `SBIE_ADDR_STATUS;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset)
            en_r <= 8'h00;
        else if (reg_req.wr && reg_req.addr == `SBIE_ADDR_ENABLE)
            en_r <= reg_req.wdata & `SBIE_IMPL_MASK;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rd_en;
        reg_req.rd && reg_req.addr == `SBIE_ADDR_ENABLE |=> reg_rdata == $past(en_r);
    endproperty
    a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");
    property p_tx_rd; tx_rd_req |=> tx_rd_data.valid; endproperty
    a_tx_rd: assert property (p_tx_rd) else $error("tx read gave no byte");
    property p_rx_rd; rx_rd_req |=> rx_rd_data.valid; endproperty
    a_rx_rd: assert property (p_rx_rd) else $error("rx read gave no byte");
    property p_tx_slip; sr |=> !(reg_rdata[7] | reg_rdata[6]) || reg_rdata[5]; endproperty
    a_tx_slip: assert property (p_tx_slip) else $error("tx slip bit missing");
    property p_rx_slip; sr |=> !(reg_rdata[2] | reg_rdata[1]) || reg_rdata[0]; endproperty
    a_rx_slip: assert property (p_rx_slip) else $error("rx slip bit missing");
    property p_clr; sr && q ##1 sr && q |=> reg_rdata == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("status not cleared by read");
    property p_irq_clr; sr && q |=> !irq; endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq held after status read");
    property p_irq_mask; en_r == 8'h00 && $past(en_r) == 8'h00 |-> !irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while all masked");
    property p_irq_src; sr ##1 (|(reg_rdata & $past(en_r, 2))) |-> $past(irq); endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq low with enabled status");
    c_tx_ovf: cover property (sr ##1 reg_rdata[7]);
    c_rx_ovf: cover property (sr ##1 reg_rdata[2]);
    c_irq: cover property (irq);
endmodule : sbie_top_props
bind sbie_top sbie_top_props sbie_top_props_i (.sys_clk(sys_clk), .reset(reset),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .tx_wr(tx_wr), .tx_rd_req(tx_rd_req),
    .tx_rd_data(tx_rd_data), .rx_wr(rx_wr), .rx_rd_req(rx_rd_req), .rx_rd_data(rx_rd_data),
    .irq(irq));

// ### tb/sbie_top_tb.sv
`timescale 1ns/1ps
`include "sbie_consts.svh"
module sbie_top_tb
    import sbie_pkg::*;
;
    logic             sys_clk = 0;
    logic             reset = 1;
    sbie_reg_req_type reg_req = '0;
    sbie_byte_type    tx_wr = '0, rx_wr = '0, tx_rd_data, rx_rd_data;
    logic             tx_rd_req = 0, rx_rd_req = 0, irq, rd_d = 0;
    logic [7:0]       reg_rdata, en, eq[$], dq[$];
    int               fails = 0, n_compared = 0, seed = 73589;
    sbie_top sbie_top_i (.sys_clk(sys_clk), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .tx_wr(tx_wr), .tx_rd_req(tx_rd_req), .tx_rd_data(tx_rd_data),
        .rx_wr(rx_wr), .rx_rd_req(rx_rd_req), .rx_rd_data(rx_rd_data), .irq(irq));
    initial forever #4 sys_clk = ~sys_clk;
    task check(input string n, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    always @(posedge sys_clk) begin
        rd_d <= reg_req.rd;
        if (rd_d) check("reg_rdata", reg_rdata, eq.pop_front());
        if (tx_rd_data.valid) check("tx_rd_data", tx_rd_data.data, dq.pop_front());
        if (rx_rd_data.valid) check("rx_rd_data", rx_rd_data.data, dq.pop_front());
    end
    task bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r,
             input logic [7:0] e);
        @(posedge sys_clk);
        reg_req <= '{a, d, w, r};
        if (r) eq.push_back(e);
    endtask : bus
    task settle;
        @(posedge sys_clk);
        reg_req <= '0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle
    // Fill to overflow, drain, then one read past empty
    task run_buf(input logic rxs);
        logic [7:0] b[66];
        for (int i = 0; i < 65; i++) begin
            b[i] = 8'($random(seed));
            @(posedge sys_clk);
            if (rxs) rx_wr <= '{1'b1, b[i]};
            else tx_wr <= '{1'b1, b[i]};
        end
        b[65] = b[33];
        for (int i = 32; i < 66; i++) begin
            dq.push_back(b[i]);
            @(posedge sys_clk);
            tx_wr <= '0;
            rx_wr <= '0;
            rx_rd_req <= rxs;
            tx_rd_req <= !rxs;
        end
        @(posedge sys_clk);
        rx_rd_req <= 0;
        tx_rd_req <= 0;
        settle;
    endtask : run_buf
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 0;
        bus(`SBIE_ADDR_ENABLE, 8'h00, 0, 1, `SBIE_ENABLE_RESET);
        bus(`SBIE_ADDR_STATUS, 8'h00, 0, 1, `SBIE_STATUS_RESET);
        bus(8'hA5, 8'hFF, 1, 0, 8'h00);
        bus(8'hA5, 8'h00, 0, 1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            en = 8'($random(seed));
            bus(`SBIE_ADDR_ENABLE, en, 1, 0, 8'h00);
            bus(`SBIE_ADDR_ENABLE, 8'h00, 0, 1, en & `SBIE_IMPL_MASK);
        end
        bus(`SBIE_ADDR_ENABLE, 8'h20, 1, 0, 8'h00);
        settle;
        $display("test registers done");
        run_buf(0);
        check("irq", {7'h00, irq}, 8'h01);
        bus(`SBIE_ADDR_STATUS, 8'h00, 0, 1, 8'hE0);
        bus(`SBIE_ADDR_STATUS, 8'h00, 0, 1, 8'h00);
        bus(`SBIE_ADDR_TX_LEVEL, 8'h00, 0, 1, 8'(`SBIE_FRAME_LEN - 1));
        settle;
        check("irq", {7'h00, irq}, 8'h00);
        $display("test tx slip done");
        run_buf(1);
        check("irq", {7'h00, irq}, 8'h00);
        bus(`SBIE_ADDR_ENABLE, 8'h01, 1, 0, 8'h00);
        settle;
        check("irq", {7'h00, irq}, 8'h01);
        bus(`SBIE_ADDR_STATUS, 8'h00, 0, 1, 8'h07);
        bus(`SBIE_ADDR_RX_LEVEL, 8'h00, 0, 1, 8'(`SBIE_FRAME_LEN - 1));
        settle;
        $display("test rx slip done");
        // Mid-run reset must drop the enable and empty the transmit buffer
        @(posedge sys_clk);
        reset <= 1;
        repeat (2) @(posedge sys_clk);
        reset <= 0;
        bus(`SBIE_ADDR_ENABLE, 8'h00, 0, 1, `SBIE_ENABLE_RESET);
        bus(`SBIE_ADDR_TX_LEVEL, 8'h00, 0, 1, 8'h00);
        settle;
        check("irq", {7'h00, irq}, 8'h00);
        $display("test reset done");
        stop_test;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        stop_test;
    end
endmodule : sbie_top_tb
